// [logic/ewp_page_buf.sv]
// Page buffer: 64 bytes with one write port and a registered read port.
// Assumes the writer and reader never touch it in the same phase.
`timescale 1ns/1ps
module ewp_page_buf (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Write port
	input wire logic wr_en,
	input wire logic [ewp_pkg::PAGE_W-1:0] wr_idx,
	input wire logic [7:0] wr_data,
	// Read port, data one cycle after the index
	input wire logic [ewp_pkg::PAGE_W-1:0] rd_idx,
	output logic [7:0] rd_data
);
	import ewp_pkg::*;

	logic [7:0] mem [PAGE_BYTES];
	logic [7:0] rd_data_r;

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data_r <= 8'h00;
		end else begin
			rd_data_r <= mem[rd_idx];
		end
	end

	assign rd_data = rd_data_r;
endmodule

// [logic/ewp_pkg.sv]
// Shared constants and types of the two-wire memory slave write path.
// Assumes one 20 MHz system clock that samples the bus pins.
package ewp_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_PER_MS = CLK_HZ / 1000;
	localparam int PWRUP_TIME_MS = 1;
	localparam int PWRUP_CYCLES = PWRUP_TIME_MS * CLK_PER_MS;
	localparam int PROG_TIME_MS = 10;
	localparam int PROG_CYCLES = PROG_TIME_MS * CLK_PER_MS;
	localparam int CNT_W = 18;
	localparam int ADDR_W = 15;
	localparam int PAGE_W = 6;
	localparam int PAGE_BYTES = 64;
	localparam int PIN_W = 5;
	localparam logic [ADDR_W-1:0] PROT_BASE = 15'h6000;
	localparam logic [ADDR_W-1:0] PTR_RST = 15'h0000;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [PIN_W-1:0] PIN_RST = 5'h18;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DEV = 3'b001,
		ST_AHI = 3'b010,
		ST_ALO = 3'b011,
		ST_WDAT = 3'b100,
		ST_RDAT = 3'b101,
		ST_SKIP = 3'b110
	} ewp_state_t;

	typedef struct packed {
		logic en;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} ewp_mem_wr_t;
endpackage

// [logic/ewp_sync.sv]
// Two-stage synchroniser for levels that arrive from outside the clock domain.
// Assumes the reset value matches the idle level of each input.
`timescale 1ns/1ps
module ewp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Levels in and out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= RST;
			q_r <= RST;
		end else begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end

	assign q = q_r;
endmodule

// [logic/ewp_top.sv]
// Two-wire slave front end of a 32K x 8 memory: byte and page writes, reads.
// Assumes the array takes one write per cycle and returns read data combinationally.
// Summary of operation
// - During programming the device releases data and ignores its address.
// - Only the master clocks the bus and makes START and STOP.
// - Data line is open drain: pull low or release.
// - With write protect high, 6000H to 7FFFH is read-only.
// - Unconnected select pins read as zero, allowing four devices.
// - Data changes only while clock is low; else START or STOP.
// - START is data falling with clock high; ignore bus until it.
// - STOP is data rising with clock high; ends every operation.
// - Address byte: five type bits, two select bits, direction bit.
// - Acknowledge address only on match, then read or write.
// - Receiver holds data low during the ninth clock.
// - When selected for write, acknowledge every received byte.
// - Reading: send 8 bits, release, continue only on master ack.
// - Page write accepts up to 64 bytes in one cycle.
// - Beyond 64 bytes the page address wraps and overwrites.
// - Valid STOP after data starts programming all buffered bytes.
// - Polling: no ack while programming, ack once finished.
// - Protected target: ack address bytes, nack first data, no write.
`timescale 1ns/1ps
module ewp_top #(
	parameter logic [4:0] DEV_TYPE = 5'h0B, // Arbitrary value.
	parameter int PWRUP_CYCLES = ewp_pkg::PWRUP_CYCLES,
	parameter int PROG_CYCLES = ewp_pkg::PROG_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Two-wire bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Strap and protect pins
	input wire logic device_select_pin_low,
	input wire logic device_select_pin_high,
	input wire logic wp_i,
	// Array side
	output ewp_pkg::ewp_mem_wr_t mem_wr,
	output logic [ewp_pkg::ADDR_W-1:0] mem_rd_addr,
	input wire logic [7:0] mem_rd_data,
	output logic prog_busy
);
	import ewp_pkg::*;

	logic [PIN_W-1:0] pins_s;
	logic scl_s;
	logic sda_s;
	logic wp_s;
	logic [1:0] sel_s;
	logic scl_d_r;
	logic sda_d_r;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic pwr_ok_r;
	logic [CNT_W-1:0] pwr_cnt_r;
	logic busy_r;
	logic [CNT_W-1:0] prog_cnt_r;
	logic prog_go;
	ewp_state_t st_r;
	logic [3:0] bit_r;
	logic [7:0] sh_r;
	logic [7:0] tx_r;
	logic oe_r;
	logic sda_o_r;
	logic mack_r;
	logic ld_r;
	logic first_r;
	logic [ADDR_W-1:0] ptr_r;
	logic [6:0] hi_r;
	logic [PAGE_BYTES-1:0] valid_r;
	logic fsm_run;
	logic byte_end;
	logic ack_end;
	logic dev_match;
	logic prot_hit;
	logic wr_ack;
	logic buf_we;
	logic rd_next;
	logic [7:0] buf_rd_data;
	logic walk_d_r;
	logic [PAGE_W-1:0] idx_d_r;
	ewp_mem_wr_t mem_wr_r;
	logic [8:0] ptr_page;

	// The clock pin is only ever sampled, never driven.
	ewp_sync #(
		.W(PIN_W),
		.RST(PIN_RST)
	) u_sync (
		.clk(ref_clk),
		.arst_n(arst_n),
		.d({scl_i, sda_i, wp_i, device_select_pin_high, device_select_pin_low}),
		.q(pins_s)
	);

	assign scl_s = pins_s[4];
	assign sda_s = pins_s[3];
	// Pad pull-downs make floating protect and select pins read low.
	assign wp_s = pins_s[2];
	assign sel_s = pins_s[1:0];

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_d_r <= 1'h1;
			sda_d_r <= 1'h1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end

	assign scl_rise = scl_s && !scl_d_r;
	assign scl_fall = !scl_s && scl_d_r;
	// A data edge while the clock stays high is a bus condition.
	assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
	assign stop_det = scl_s && scl_d_r && !sda_d_r && sda_s;

	// The bus is ignored until the power-up delay has run out.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pwr_cnt_r <= '0;
			pwr_ok_r <= 1'h0;
		end else if (!pwr_ok_r) begin
			if (pwr_cnt_r == CNT_W'(PWRUP_CYCLES - 1)) begin
				pwr_ok_r <= 1'h1;
			end else begin
				pwr_cnt_r <= pwr_cnt_r + 1'b1;
			end
		end
	end

	assign fsm_run = pwr_ok_r && !busy_r && !start_det && !stop_det
		&& st_r != ST_IDLE && st_r != ST_SKIP;
	assign byte_end = fsm_run && scl_fall && bit_r == BIT_LAST;
	assign ack_end = fsm_run && scl_fall && bit_r == BIT_ACK;
	assign dev_match = sh_r[7:3] == DEV_TYPE && sh_r[2:1] == sel_s;
	assign prot_hit = wp_s && ptr_r >= PROT_BASE;
	assign wr_ack = !(first_r && prot_hit);
	assign buf_we = byte_end && st_r == ST_WDAT && wr_ack;
	assign rd_next = ack_end && st_r == ST_RDAT && (ld_r || mack_r);
	assign prog_go = stop_det && st_r == ST_WDAT && |valid_r && !busy_r;

	// Self-timed programming; the page is committed in its first cycles.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_r <= 1'h0;
			prog_cnt_r <= '0;
		end else if (prog_go) begin
			busy_r <= 1'h1;
			prog_cnt_r <= '0;
		end else if (busy_r) begin
			if (prog_cnt_r == CNT_W'(PROG_CYCLES - 1)) begin
				busy_r <= 1'h0;
			end else begin
				prog_cnt_r <= prog_cnt_r + 1'b1;
			end
		end
	end

	// Holds up to one full page of received data.
	ewp_page_buf u_buf (
		.clk(ref_clk),
		.arst_n(arst_n),
		.wr_en(buf_we),
		.wr_idx(ptr_r[PAGE_W-1:0]),
		.wr_data(sh_r),
		.rd_idx(prog_cnt_r[PAGE_W-1:0]),
		.rd_data(buf_rd_data)
	);

	// Only bytes received in this transaction reach the array.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			walk_d_r <= 1'h0;
			idx_d_r <= '0;
			mem_wr_r <= '0;
		end else begin
			walk_d_r <= busy_r && prog_cnt_r < CNT_W'(PAGE_BYTES);
			idx_d_r <= prog_cnt_r[PAGE_W-1:0];
			mem_wr_r.en <= walk_d_r && valid_r[idx_d_r];
			mem_wr_r.addr <= {ptr_r[ADDR_W-1:PAGE_W], idx_d_r};
			mem_wr_r.data <= buf_rd_data;
		end
	end

	// Address pointer and page byte marks.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ptr_r <= PTR_RST;
			hi_r <= '0;
			valid_r <= '0;
		end else begin
			if (byte_end && st_r == ST_AHI) begin
				hi_r <= sh_r[6:0];
			end
			if (byte_end && st_r == ST_ALO) begin
				ptr_r <= {hi_r, sh_r};
				valid_r <= '0;
			end
			if (buf_we) begin
				valid_r[ptr_r[PAGE_W-1:0]] <= 1'h1;
				// Only the in-page bits count, so the page wraps.
				ptr_r[PAGE_W-1:0] <= ptr_r[PAGE_W-1:0] + 1'b1;
			end
			if (rd_next) begin
				ptr_r <= ptr_r + 1'b1;
			end
		end
	end

	// Bus protocol engine; bit_r counts clock falls within a 9-clock byte slot.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= ST_IDLE;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			tx_r <= 8'h00;
			oe_r <= 1'h0;
			mack_r <= 1'h0;
			ld_r <= 1'h0;
			first_r <= 1'h0;
		end else if (busy_r || !pwr_ok_r) begin
			st_r <= ST_IDLE;
			oe_r <= 1'h0;
		end else if (start_det) begin
			st_r <= ST_DEV;
			// The START's own clock fall closes a notional acknowledge slot.
			bit_r <= BIT_ACK;
			oe_r <= 1'h0;
		end else if (stop_det) begin
			st_r <= ST_IDLE;
			oe_r <= 1'h0;
		end else if (fsm_run) begin
			if (scl_rise) begin
				if (bit_r != BIT_ACK) begin
					sh_r <= {sh_r[6:0], sda_s};
				end else begin
					mack_r <= !sda_s;
				end
			end
			if (scl_fall) begin
				bit_r <= (bit_r == BIT_ACK) ? 4'h0 : bit_r + 4'h1;
			end
			if (byte_end) begin
				unique case (st_r)
					ST_DEV: begin
						if (dev_match) begin
							oe_r <= 1'h1;
							st_r <= sh_r[0] ? ST_RDAT : ST_AHI;
							ld_r <= sh_r[0];
						end else begin
							st_r <= ST_SKIP;
						end
					end
					ST_AHI: begin
						oe_r <= 1'h1;
						st_r <= ST_ALO;
					end
					ST_ALO: begin
						oe_r <= 1'h1;
						st_r <= ST_WDAT;
						first_r <= 1'h1;
					end
					ST_WDAT: begin
						first_r <= 1'h0;
						if (wr_ack) begin
							oe_r <= 1'h1;
						end else begin
							st_r <= ST_SKIP;
						end
					end
					ST_RDAT: begin
						oe_r <= 1'h0;
					end
				endcase
			end else if (ack_end) begin
				if (rd_next) begin
					oe_r <= !mem_rd_data[7];
					tx_r <= {mem_rd_data[6:0], 1'h0};
					ld_r <= 1'h0;
				end else begin
					oe_r <= 1'h0;
					if (st_r == ST_RDAT) begin
						st_r <= ST_SKIP;
					end
				end
			end else if (scl_fall && st_r == ST_RDAT) begin
				oe_r <= !tx_r[7];
				tx_r <= {tx_r[6:0], 1'h0};
			end
		end
	end

	// The data pad only ever pulls low.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sda_o_r <= 1'h0;
		end else begin
			sda_o_r <= 1'h0;
		end
	end

	assign sda_o = sda_o_r;
	assign sda_oe = oe_r;
	assign mem_wr = mem_wr_r;
	assign mem_rd_addr = ptr_r;
	assign prog_busy = busy_r;
	assign ptr_page = ptr_r[ADDR_W-1:PAGE_W];

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	AST_BUSY_SILENT: assert property (busy_r |-> !oe_r && st_r == ST_IDLE)
		else $error("Bus driven or engaged while programming.");
	AST_OPEN_DRAIN: assert property (sda_oe |-> sda_o == 1'h0)
		else $error("Data pad driven high.");
	AST_OE_RISE_LOW: assert property ($rose(oe_r) |-> !scl_s)
		else $error("Data line pulled while clock high.");
	AST_START_SEEN: assert property (start_det && !busy_r && pwr_ok_r |=> st_r == ST_DEV && bit_r == BIT_ACK)
		else $error("START not taken.");
	AST_IDLE_DEAF: assert property (st_r == ST_IDLE && !start_det |=> st_r == ST_IDLE && !oe_r)
		else $error("Left idle without START.");
	AST_STOP_ENDS: assert property (stop_det && !start_det |=> st_r == ST_IDLE)
		else $error("STOP not recognised.");
	AST_ACK_MATCH: assert property (byte_end && st_r == ST_DEV && dev_match |=> oe_r)
		else $error("Matching address not acknowledged.");
	AST_NACK_OTHER: assert property (byte_end && st_r == ST_DEV && !dev_match |=> !oe_r [*2])
		else $error("Foreign address acknowledged.");
	AST_ADDR_ACK: assert property (byte_end && (st_r == ST_AHI || st_r == ST_ALO) |=> oe_r)
		else $error("Address byte not acknowledged.");
	AST_WR_ACK: assert property (byte_end && st_r == ST_WDAT && wr_ack |=> oe_r)
		else $error("Write data not acknowledged.");
	AST_PROT_NACK: assert property (byte_end && st_r == ST_WDAT && first_r && prot_hit |=> !oe_r && st_r == ST_SKIP && !buf_we)
		else $error("Protected byte acknowledged.");
	AST_RD_RELEASE: assert property (byte_end && st_r == ST_RDAT |=> !oe_r)
		else $error("Line held during master acknowledge.");
	AST_PAGE_KEPT: assert property (st_r == ST_WDAT && $past(st_r) == ST_WDAT |-> ptr_page == $past(ptr_page))
		else $error("Page bits changed during write.");
	AST_ADDR_FORM: assert property (byte_end && st_r == ST_ALO |=> ptr_r == {hi_r, $past(sh_r)})
		else $error("Address not formed from two bytes.");
	AST_PROG_GO: assert property (prog_go |=> busy_r ##1 busy_r)
		else $error("Programming not started after STOP.");

	COV_BYTE_WRITE: cover property (prog_go);
	COV_READ_ACK: cover property (rd_next && !ld_r);
	COV_POLL_BUSY: cover property (start_det && busy_r);
	COV_PAGE_WRAP: cover property (buf_we && ptr_r[PAGE_W-1:0] == 6'h3F);
endmodule

// [tb/ewp_master.sv]
// Bus master model: makes the serial clock and pulls the data line low.
// Assumes a pull-up on the data line and calls that start off the clock grid.
`timescale 1ns/1ps
module ewp_master (
	// Bus lines
	output logic scl,
	output logic pull_low,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		pull_low = 1'b0;
	end
	// One bit slot; data moves only while the clock is low.
	task automatic slot(input logic b, output logic r);
		#150 pull_low = !b;
		#50 scl = 1'b1;
		#100 r = sda;
		#100 scl = 1'b0;
	endtask
	task automatic start();
		#150 pull_low = 1'b0;
		#50 scl = 1'b1;
		#100 pull_low = 1'b1;
		#100 scl = 1'b0;
	endtask
	task automatic stop();
		#150 pull_low = 1'b1;
		#50 scl = 1'b1;
		#100 pull_low = 1'b0;
		#100;
	endtask
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			slot(d[i], r);
		end
		slot(1'b1, r);
		ack = !r;
	endtask
	task automatic get(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			slot(1'b1, r);
			d[i] = r;
		end
		slot(!ack, r);
	endtask
endmodule

// [tb/ewp_top_tb.sv]
// Self-checking bench of the two-wire memory slave write path.
// Assumes the bus master model and a behavioural array on the memory side.
`timescale 1ns/1ps
module ewp_top_tb;
	import ewp_pkg::*;
	localparam logic [4:0] TYPE_C = 5'h0B; // Arbitrary value.
	localparam int PROG_N = 100;
	localparam logic [10:0] ROWS [8] = '{
		{3'b100, TYPE_C, 3'b000}, {3'b000, TYPE_C, 3'b010}, {3'b110, TYPE_C, 3'b100},
		{3'b111, TYPE_C, 3'b110}, {3'b101, TYPE_C, 3'b010}, {3'b011, TYPE_C, 3'b100},
		{3'b000, ~TYPE_C, 3'b000}, {3'b000, TYPE_C ^ 5'h10, 3'b000}};
	localparam logic [25:0] WP_ROWS [5] = '{
		{2'b01, 16'h6000, 8'h11}, {2'b11, 16'hDFFF, 8'h22}, {2'b01, 16'h7FFF, 8'h33},
		{2'b10, 16'h7FFF, 8'h44}, {2'b10, 16'h0000, 8'h55}};
	logic ref_clk, arst_n, scl, m_low, sda, sda_out, oe, sel_lo, sel_hi, wp, busy;
	ewp_mem_wr_t mem_wr;
	logic [ADDR_W-1:0] rd_addr;
	logic [7:0] rd_data;
	logic [7:0] mem [0:32767];
	int n_errors = 0;
	int num_checks = 0;
	int n_wr = 0;
	assign sda = !(m_low | oe);
	assign rd_data = mem[rd_addr];
	ewp_master bus (.scl(scl), .pull_low(m_low), .sda(sda));
	ewp_top #(.DEV_TYPE(TYPE_C), .PWRUP_CYCLES(10), .PROG_CYCLES(PROG_N)) dut (
		.ref_clk(ref_clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_out),
		.sda_oe(oe), .device_select_pin_low(sel_lo), .device_select_pin_high(sel_hi),
		.wp_i(wp), .mem_wr(mem_wr), .mem_rd_addr(rd_addr), .mem_rd_data(rd_data),
		.prog_busy(busy));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = !ref_clk;
	end
	always @(posedge ref_clk) begin
		if (mem_wr.en === 1'b1) begin
			mem[mem_wr.addr] <= mem_wr.data;
			n_wr++;
		end
	end
	function automatic logic [7:0] seed_val(input int a);
		return 8'(a) ^ 8'h5A;
	endfunction
	task automatic chk1(input string nm, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Realigns the bench to a point clear of both clock edges.
	task automatic settle(input int n);
		repeat (n) @(negedge ref_clk);
		#10;
	endtask
	task automatic hdr(input logic [15:0] a);
		logic k;
		bus.start();
		bus.put({TYPE_C, sel_hi, sel_lo, 1'b0}, k);
		chk1("dev ack", 1'b1, k);
		bus.put(a[15:8], k);
		chk1("hi ack", 1'b1, k);
		bus.put(a[7:0], k);
		chk1("lo ack", 1'b1, k);
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 3 * PROG_N) begin
			@(negedge ref_clk);
			n++;
		end
		chk1("busy end", 1'b0, busy);
		settle(1);
	endtask
	task automatic wr1(input logic [15:0] a, input logic [7:0] d, input logic e);
		logic k;
		hdr(a);
		bus.put(d, k);
		chk1("data ack", e, k);
		bus.stop();
		settle(4);
		chk1("busy", e, busy);
		wait_done();
		chk8("cell", e ? d : seed_val(a[14:0]), mem[a[14:0]]);
	endtask
	initial begin
		logic k;
		logic [7:0] d;
		arst_n = 1'b0;
		sel_lo = 1'b0;
		sel_hi = 1'b0;
		wp = 1'b0;
		for (int i = 0; i < 32768; i++) begin
			mem[i] = seed_val(i);
		end
		repeat (20) @(negedge ref_clk);
		chk1("oe rst", 1'b0, oe);
		chk1("pad rst", 1'b0, sda_out);
		chk1("busy rst", 1'b0, busy);
		chk1("ptr rst", 1'b1, rd_addr === PTR_RST);
		arst_n = 1'b1;
		settle(20);
		foreach (ROWS[i]) begin
			@(negedge ref_clk);
			{sel_hi, sel_lo} = ROWS[i][9:8];
			settle(4);
			bus.start();
			bus.put(ROWS[i][7:0], k);
			chk1("match", ROWS[i][10], k);
			bus.stop();
		end
		@(negedge ref_clk);
		{sel_hi, sel_lo} = 2'b00;
		settle(4);
		chk1("no dummy prog", 1'b0, busy);
		hdr(16'hA1BE);
		for (int i = 0; i < 66; i++) begin
			bus.put(8'(i), k);
			chk1("page ack", 1'b1, k);
		end
		n_wr = 0;
		bus.stop();
		settle(4);
		bus.start();
		bus.put({TYPE_C, 3'b000}, k);
		chk1("poll busy", 1'b0, k);
		bus.stop();
		wait_done();
		chk8("writes", 8'd64, 8'(n_wr));
		for (int m = 0; m < 64; m++) begin
			chk8("page", 8'(m + 2), mem[16'h2180 + m]);
		end
		chk8("below", seed_val(16'h217F), mem[16'h217F]);
		chk8("above", seed_val(16'h21C0), mem[16'h21C0]);
		bus.start();
		bus.put({TYPE_C, 3'b000}, k);
		chk1("poll done", 1'b1, k);
		bus.stop();
		hdr(16'h21BE);
		bus.start();
		bus.put({TYPE_C, 3'b001}, k);
		chk1("rd ack", 1'b1, k);
		bus.get(1'b1, d);
		chk8("rd0", 8'd64, d);
		bus.get(1'b0, d);
		chk8("rd1", 8'd65, d);
		bus.stop();
		chk1("oe idle", 1'b0, oe);
		foreach (WP_ROWS[i]) begin
			@(negedge ref_clk);
			wp = WP_ROWS[i][24];
			settle(4);
			wr1(WP_ROWS[i][23:8], WP_ROWS[i][7:0], WP_ROWS[i][25]);
		end
		print_verdict();
	end
	initial begin
		#2_000_000;
		n_errors++;
		print_verdict();
	end
endmodule
